// file: core/cct_pkg.sv
// Constants, register map and carrier types for the CAN control and timestamp block.
// Assumes an APB master with 32-bit data; other control bits arrive as inputs.
// Operation
// - Bits 12, 7, 5, 4 and 3 writable only while inactive
// - Soft reset leaves control register unchanged
// - Bus-off interrupt gated by bit 15
// - Error summary interrupt gated by bit 14
// - Bit 12 selects loopback-silent mode
// - Loopback-silent forces self-reception-disable, delay-comp low
// - Warning enables writable only with warning feature
// - Tx warning interrupt gated by bit 11
// - Rx warning interrupt gated by bit 10
// - Bit 7 selects one or three samples
// - Bit 6 disables automatic bus-off recovery
// - Time sync only when bit 5 set
// - Bit 4 selects transmit mailbox order
// - Bit 3 selects monitor mode
// - Timer reads 16-bit counter, upper zero
// - Warning flags follow status with feature enabled
package cct_pkg;
    localparam logic [11:0] CCT_OFF_CTRL2 = 12'h004;
    localparam logic [11:0] CCT_OFF_TIMER = 12'h008;
    localparam logic [11:0] CCT_OFF_IRQ_STAT = 12'h00c;
    localparam logic [11:0] CCT_OFF_IRQ_EN = 12'h010;
    localparam logic [11:0] CCT_OFF_IRQ_CLR = 12'h014;
    localparam logic [31:0] CCT_CTRL2_RESET = 32'h00000000;
    localparam logic [15:0] CCT_TIMER_RESET = 16'h0000;
    localparam logic [3:0] CCT_IRQ_RESET = 4'h0;
    localparam int CCT_BIT_BUSOFF_IE = 15;
    localparam int CCT_BIT_ERRSUM_IE = 14;
    localparam int CCT_BIT_LSM = 12;
    localparam int CCT_BIT_TXW_IE = 11;
    localparam int CCT_BIT_RXW_IE = 10;
    localparam int CCT_BIT_TRIPLE = 7;
    localparam int CCT_BIT_NOREC = 6;
    localparam int CCT_BIT_TIME_SYNC = 5;
    localparam int CCT_BIT_ORDER = 4;
    localparam int CCT_BIT_MONITOR = 3;
    localparam logic [31:0] CCT_LOCKED_MASK = 32'h000010b8;
    localparam logic [31:0] CCT_WARN_MASK = 32'h00000c00;
    localparam logic [31:0] CCT_FREE_MASK = 32'h0000c040;
    localparam int CCT_EV_BUSOFF = 0;
    localparam int CCT_EV_ERRSUM = 1;
    localparam int CCT_EV_TXW = 2;
    localparam int CCT_EV_RXW = 3;
    localparam int CCT_NUM_EV = 4;
    localparam int CCT_TS_W = 16;

    typedef struct packed {
        logic busoff_irq_enable;
        logic error_summary_irq_enable;
        logic loopback_silent_select;
        logic tx_warning_irq_enable;
        logic rx_warning_irq_enable;
        logic triple_sample_select;
        logic auto_recovery_disable;
        logic time_sync_enable;
        logic tx_order_select;
        logic monitor_select;
    } cct_mode_t;

    typedef struct packed {
        logic busoff;
        logic error_summary;
        logic tx_warning;
        logic rx_warning;
    } cct_event_t;
endpackage

// file: core/cct_timestamp.sv
// Free-running timestamp counter with load and sync inputs.
// Assumes load and sync come from logic on the same clock.
`timescale 1ns/1ps
module cct_timestamp #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic sync,
    output logic [WIDTH-1:0] value
);
    // Counts every cycle, wraps to zero; sync clears
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value <= '0;
        end else if (load) begin
            value <= load_value;
        end else if (sync) begin
            value <= '0;
        end else begin
            value <= value + WIDTH'(1);
        end
    end
endmodule // cct_timestamp

// file: core/cct_ctrl_timer.sv
// Second control register, timestamp timer and event interrupts behind APB.
// Assumes inactive, warning-feature and event inputs are asynchronous to CLK.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module cct_ctrl_timer (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INACTIVE_MODE,
    input wire logic SOFT_RESET_REQUEST,
    input wire logic WARNING_FEATURE_ENABLE,
    input wire logic SELF_RECEPTION_DISABLE_REQ,
    input wire logic TX_DELAY_COMP_ENABLE_REQ,
    input wire logic BUSOFF_EVENT,
    input wire logic ERROR_SUMMARY_EVENT,
    input wire logic TX_WARNING_STATUS,
    input wire logic RX_WARNING_STATUS,
    input wire logic TIME_SYNC_EVENT,
    output cct_pkg::cct_mode_t MODE,
    output logic SELF_RECEPTION_DISABLE,
    output logic TX_DELAY_COMP_ENABLE,
    output logic BUSOFF_IRQ,
    output logic ERROR_SUMMARY_IRQ,
    output logic TX_WARNING_IRQ_FLAG,
    output logic RX_WARNING_IRQ_FLAG,
    output logic IRQ
);
    localparam int NS = 9;

    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] async_in;
    logic inactive;
    logic warn_en;
    logic self_rx_dis_req;
    logic tdc_req;
    logic ev_busoff;
    logic ev_errsum;
    logic txw_stat;
    logic rxw_stat;
    logic time_sync_ev;
    logic txw_prev;
    logic rxw_prev;
    logic time_sync_prev;
    logic [31:0] ctrl2;
    logic [cct_pkg::CCT_NUM_EV-1:0] irq_stat;
    logic [cct_pkg::CCT_NUM_EV-1:0] irq_en;
    logic [cct_pkg::CCT_NUM_EV-1:0] ev_set;
    logic [cct_pkg::CCT_NUM_EV-1:0] ev_clr;
    logic [15:0] ts_value;
    logic setup;
    logic wr;
    logic rd;
    logic full_word;
    logic mapped;
    logic [31:0] wmask;
    logic [31:0] next_ctrl2;
    logic [31:0] ctrl2_view;
    logic [31:0] next_rdata;
    logic ts_load;
    logic ts_sync;

    assign async_in = {TIME_SYNC_EVENT, RX_WARNING_STATUS, TX_WARNING_STATUS, ERROR_SUMMARY_EVENT,
                       BUSOFF_EVENT, TX_DELAY_COMP_ENABLE_REQ, SELF_RECEPTION_DISABLE_REQ,
                       WARNING_FEATURE_ENABLE, INACTIVE_MODE};

    // Two-flop synchronisers
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= async_in;
            sync2 <= sync1;
        end
    end

    assign {time_sync_ev, rxw_stat, txw_stat, ev_errsum, ev_busoff, tdc_req, self_rx_dis_req, warn_en,
            inactive} = sync2;

    // Single-cycle zero-wait APB
    assign setup = PSEL && !PENABLE;
    assign wr = setup && PWRITE;
    assign rd = setup && !PWRITE;
    assign full_word = (PSTRB == 4'hf);
    assign mapped = (PADDR == cct_pkg::CCT_OFF_CTRL2) || (PADDR == cct_pkg::CCT_OFF_TIMER) ||
                    (PADDR == cct_pkg::CCT_OFF_IRQ_STAT) || (PADDR == cct_pkg::CCT_OFF_IRQ_EN) ||
                    (PADDR == cct_pkg::CCT_OFF_IRQ_CLR);

    // Writable bits depend on mode and warning feature
    always_comb begin
        wmask = cct_pkg::CCT_FREE_MASK;
        if (inactive) begin
            wmask = wmask | cct_pkg::CCT_LOCKED_MASK;
        end
        if (warn_en) begin
            wmask = wmask | cct_pkg::CCT_WARN_MASK;
        end
        next_ctrl2 = (ctrl2 & ~wmask) | (PWDATA & wmask);
    end

    // Only full reset clears it; the soft reset request input is not used here
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl2 <= cct_pkg::CCT_CTRL2_RESET;
        end else if (wr && full_word && PADDR == cct_pkg::CCT_OFF_CTRL2) begin
            ctrl2 <= next_ctrl2;
        end
    end

    // Warning enables read zero while feature off
    assign ctrl2_view = warn_en ? ctrl2 : (ctrl2 & ~cct_pkg::CCT_WARN_MASK);

    always_comb begin
        next_rdata = 32'h00000000;
        case (PADDR)
            cct_pkg::CCT_OFF_CTRL2: next_rdata = ctrl2_view;
            cct_pkg::CCT_OFF_TIMER: next_rdata = {16'h0000, ts_value};
            cct_pkg::CCT_OFF_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
            cct_pkg::CCT_OFF_IRQ_EN: next_rdata = {28'h0000000, irq_en};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Answer in the access phase; error on unmapped or partial timer write
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup && (!mapped || (PWRITE && PADDR == cct_pkg::CCT_OFF_TIMER && !full_word));
            if (rd) begin
                PRDATA <= next_rdata;
            end
        end
    end

    // Timestamp counter, loaded by word write, cleared by sync event
    assign ts_load = wr && full_word && PADDR == cct_pkg::CCT_OFF_TIMER;
    assign ts_sync = ctrl2[cct_pkg::CCT_BIT_TIME_SYNC] && time_sync_ev && !time_sync_prev;

    cct_timestamp #(
        .WIDTH(cct_pkg::CCT_TS_W)
    ) u_timestamp (
        .clk(CLK),
        .resetn(RESETN),
        .load(ts_load),
        .load_value(PWDATA[15:0]),
        .sync(ts_sync),
        .value(ts_value)
    );

    // Edge history of warning status and sync
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            txw_prev <= 1'b0;
            rxw_prev <= 1'b0;
            time_sync_prev <= 1'b0;
        end else begin
            txw_prev <= txw_stat;
            rxw_prev <= rxw_stat;
            time_sync_prev <= time_sync_ev;
        end
    end

    // Events: warning flags follow status changes only with feature on
    always_comb begin
        ev_set = '0;
        ev_set[cct_pkg::CCT_EV_BUSOFF] = ev_busoff;
        ev_set[cct_pkg::CCT_EV_ERRSUM] = ev_errsum;
        ev_set[cct_pkg::CCT_EV_TXW] = warn_en && (txw_stat != txw_prev);
        ev_set[cct_pkg::CCT_EV_RXW] = warn_en && (rxw_stat != rxw_prev);
    end

    assign ev_clr = (wr && PADDR == cct_pkg::CCT_OFF_IRQ_CLR) ? PWDATA[cct_pkg::CCT_NUM_EV-1:0] : '0;

    // Sticky status, set wins over clear
    genvar g;
    generate
        for (g = 0; g < cct_pkg::CCT_NUM_EV; g++) begin : g_stat
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    irq_stat[g] <= 1'b0;
                end else if (ev_set[g]) begin
                    irq_stat[g] <= 1'b1;
                end else if (ev_clr[g]) begin
                    irq_stat[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_en <= cct_pkg::CCT_IRQ_RESET;
        end else if (wr && PADDR == cct_pkg::CCT_OFF_IRQ_EN) begin
            irq_en <= PWDATA[cct_pkg::CCT_NUM_EV-1:0];
        end
    end

    // Interrupt lines gated by control enables; IRQ gated by the irq_en register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            BUSOFF_IRQ <= 1'b0;
            ERROR_SUMMARY_IRQ <= 1'b0;
            TX_WARNING_IRQ_FLAG <= 1'b0;
            RX_WARNING_IRQ_FLAG <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            BUSOFF_IRQ <= irq_stat[cct_pkg::CCT_EV_BUSOFF] && ctrl2[cct_pkg::CCT_BIT_BUSOFF_IE];
            ERROR_SUMMARY_IRQ <= irq_stat[cct_pkg::CCT_EV_ERRSUM] && ctrl2[cct_pkg::CCT_BIT_ERRSUM_IE];
            TX_WARNING_IRQ_FLAG <= irq_stat[cct_pkg::CCT_EV_TXW] && ctrl2_view[cct_pkg::CCT_BIT_TXW_IE];
            RX_WARNING_IRQ_FLAG <= irq_stat[cct_pkg::CCT_EV_RXW] && ctrl2_view[cct_pkg::CCT_BIT_RXW_IE];
            IRQ <= |(irq_stat & irq_en);
        end
    end

    // Mode outputs to the protocol engine
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            MODE <= '0;
            SELF_RECEPTION_DISABLE <= 1'b0;
            TX_DELAY_COMP_ENABLE <= 1'b0;
        end else begin
            MODE.busoff_irq_enable <= ctrl2[cct_pkg::CCT_BIT_BUSOFF_IE];
            MODE.error_summary_irq_enable <= ctrl2[cct_pkg::CCT_BIT_ERRSUM_IE];
            MODE.loopback_silent_select <= ctrl2[cct_pkg::CCT_BIT_LSM];
            MODE.tx_warning_irq_enable <= ctrl2_view[cct_pkg::CCT_BIT_TXW_IE];
            MODE.rx_warning_irq_enable <= ctrl2_view[cct_pkg::CCT_BIT_RXW_IE];
            MODE.triple_sample_select <= ctrl2[cct_pkg::CCT_BIT_TRIPLE];
            MODE.auto_recovery_disable <= ctrl2[cct_pkg::CCT_BIT_NOREC];
            MODE.time_sync_enable <= ctrl2[cct_pkg::CCT_BIT_TIME_SYNC];
            MODE.tx_order_select <= ctrl2[cct_pkg::CCT_BIT_ORDER];
            MODE.monitor_select <= ctrl2[cct_pkg::CCT_BIT_MONITOR];
            SELF_RECEPTION_DISABLE <= self_rx_dis_req && !ctrl2[cct_pkg::CCT_BIT_LSM];
            TX_DELAY_COMP_ENABLE <= tdc_req && !ctrl2[cct_pkg::CCT_BIT_LSM];
        end
    end
endmodule // cct_ctrl_timer

// file: verification/cct_checker.sv
// Checker for register answers, mode locks and interrupt gating.
// Assumes binding onto cct_ctrl_timer; one clock domain.
`timescale 1ns/1ps
module cct_checker (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic INACTIVE_MODE,
    input wire logic WARNING_FEATURE_ENABLE,
    input wire cct_pkg::cct_mode_t MODE,
    input wire logic SELF_RECEPTION_DISABLE,
    input wire logic TX_DELAY_COMP_ENABLE,
    input wire logic BUSOFF_IRQ,
    input wire logic ERROR_SUMMARY_IRQ,
    input wire logic TX_WARNING_IRQ_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic [3:0] act_h;
    logic [3:0] wof_h;
    wire logic lock = &act_h && !INACTIVE_MODE;
    wire logic [4:0] lk = {MODE.loopback_silent_select, MODE.triple_sample_select, MODE.time_sync_enable,
        MODE.tx_order_select, MODE.monitor_select};
    wire logic rd = PREADY && !PWRITE;
    // History of active mode and warning feature off
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            act_h <= 4'h0;
            wof_h <= 4'h0;
        end else begin
            act_h <= {act_h[2:0], !INACTIVE_MODE};
            wof_h <= {wof_h[2:0], !WARNING_FEATURE_ENABLE};
        end
    end
    property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("Answer timing wrong");
    property p_unmap; PREADY && !(PADDR inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014}) |-> PSLVERR; endproperty
    a_unmap: assert property (p_unmap) else $error("Unmapped access accepted");
    property p_lock; lock |=> $stable(lk); endproperty
    a_lock: assert property (p_lock) else $error("Locked bits changed");
    property p_busoff; BUSOFF_IRQ |-> MODE.busoff_irq_enable || $past(MODE.busoff_irq_enable); endproperty
    a_busoff: assert property (p_busoff) else $error("Bus-off irq not gated");
    property p_errsum; ERROR_SUMMARY_IRQ |-> MODE.error_summary_irq_enable || $past(MODE.error_summary_irq_enable);
    endproperty
    a_errsum: assert property (p_errsum) else $error("Error summary irq not gated");
    property p_txw; TX_WARNING_IRQ_FLAG |-> MODE.tx_warning_irq_enable || $past(MODE.tx_warning_irq_enable); endproperty
    a_txw: assert property (p_txw) else $error("Tx warning flag not gated");
    property p_lsm; MODE.loopback_silent_select && $past(MODE.loopback_silent_select)
        |-> !SELF_RECEPTION_DISABLE && !TX_DELAY_COMP_ENABLE; endproperty
    a_lsm: assert property (p_lsm) else $error("Loopback-silent did not force low");
    property p_warnrd; rd && PADDR == 12'h004 && &wof_h |-> PRDATA[11:10] == 2'b00; endproperty
    a_warnrd: assert property (p_warnrd) else $error("Warning enables not read as zero");
    property p_timer; rd && PADDR == 12'h008 |-> PRDATA[31:16] == 16'h0000; endproperty
    a_timer: assert property (p_timer) else $error("Timer upper half not zero");
endmodule // cct_checker

// file: verification/cct_bus_node.sv
// Far-side model: error, warning and sync events from the bus side.
// Assumes commands arrive just after a rising edge.
`timescale 1ns/1ps
module cct_bus_node (
    input wire logic clk,
    input wire logic fire,
    input wire logic [2:0] kind,
    input wire logic [3:0] len,
    output cct_pkg::cct_event_t ev,
    output logic time_sync
);
    logic [3:0] left = 4'h0;
    logic [2:0] cur = 3'h0;
    logic txw = 1'b0;
    logic rxw = 1'b0;
    wire logic on = left != 4'h0;
    assign ev = {on && cur == 3'h0, on && cur == 3'h1, txw, rxw};
    assign time_sync = on && cur == 3'h4;
    // Pulses last len cycles; warning kinds toggle the level
    always @(posedge clk) begin
        if (fire) begin
            left <= len;
            cur <= kind;
            txw <= txw ^ (kind == 3'h2);
            rxw <= rxw ^ (kind == 3'h3);
        end else if (on) begin
            left <= left - 4'h1;
        end
    end
endmodule // cct_bus_node

// file: verification/cct_ctrl_timer_tb_top.sv
// Testbench: control register, locks, interrupts and timestamp timer.
// Assumes package, design, checker and bus node model compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module cct_ctrl_timer_tb_top;
    logic CLK = 1'b0, RESETN, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [3:0] PSTRB = 4'hf;
    logic INACTIVE_MODE = 1'b1, SOFT_RESET_REQUEST = 1'b0, WARNING_FEATURE_ENABLE = 1'b0;
    logic SELF_RECEPTION_DISABLE_REQ = 1'b0, TX_DELAY_COMP_ENABLE_REQ = 1'b0, fire = 1'b0;
    logic [2:0] kind = 3'h0;
    logic PREADY, PSLVERR, BUSOFF_EVENT, ERROR_SUMMARY_EVENT, TX_WARNING_STATUS, RX_WARNING_STATUS, err;
    logic TIME_SYNC_EVENT, SELF_RECEPTION_DISABLE, TX_DELAY_COMP_ENABLE, BUSOFF_IRQ, ERROR_SUMMARY_IRQ;
    logic TX_WARNING_IRQ_FLAG, RX_WARNING_IRQ_FLAG, IRQ;
    cct_pkg::cct_mode_t MODE;
    cct_pkg::cct_event_t ev;
    int failures = 0, cmp_count = 0;
    assign {BUSOFF_EVENT, ERROR_SUMMARY_EVENT, TX_WARNING_STATUS, RX_WARNING_STATUS} = ev;
    always #20 CLK = !CLK;
    cct_ctrl_timer cct_ctrl_timer_i (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .INACTIVE_MODE(INACTIVE_MODE), .SOFT_RESET_REQUEST(SOFT_RESET_REQUEST),
        .WARNING_FEATURE_ENABLE(WARNING_FEATURE_ENABLE), .SELF_RECEPTION_DISABLE_REQ(SELF_RECEPTION_DISABLE_REQ),
        .TX_DELAY_COMP_ENABLE_REQ(TX_DELAY_COMP_ENABLE_REQ), .BUSOFF_EVENT(BUSOFF_EVENT),
        .ERROR_SUMMARY_EVENT(ERROR_SUMMARY_EVENT), .TX_WARNING_STATUS(TX_WARNING_STATUS),
        .RX_WARNING_STATUS(RX_WARNING_STATUS), .TIME_SYNC_EVENT(TIME_SYNC_EVENT), .MODE(MODE),
        .SELF_RECEPTION_DISABLE(SELF_RECEPTION_DISABLE), .TX_DELAY_COMP_ENABLE(TX_DELAY_COMP_ENABLE),
        .BUSOFF_IRQ(BUSOFF_IRQ), .ERROR_SUMMARY_IRQ(ERROR_SUMMARY_IRQ), .TX_WARNING_IRQ_FLAG(TX_WARNING_IRQ_FLAG),
        .RX_WARNING_IRQ_FLAG(RX_WARNING_IRQ_FLAG), .IRQ(IRQ));
    cct_bus_node cct_bus_node_i (.clk(CLK), .fire(fire), .kind(kind), .len(4'h2), .ev(ev),
        .time_sync(TIME_SYNC_EVENT));
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= 4'hf;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 20);
        if (n == 20) begin failures++; complete_run(); end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic hit(input logic [2:0] k);
        @(posedge CLK);
        fire <= 1'b1;
        kind <= k;
        @(posedge CLK);
        fire <= 1'b0;
        tick(10);
    endtask
    task automatic t_reset;
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0)
        apb(0, 12'h020, 0);
        `CHK({err, rd}, 33'h100000000)
        $display("t_reset done");
    endtask
    task automatic t_lock;
        INACTIVE_MODE <= 1'b0;
        tick(6);
        apb(1, 12'h004, 32'hffffffff);
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0000c040)
        `CHK(MODE, 10'h308)
        INACTIVE_MODE <= 1'b1;
        WARNING_FEATURE_ENABLE <= 1'b1;
        tick(6);
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0000c040)
        apb(1, 12'h004, 32'h0000dcf8);
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0000dcf8)
        `CHK(MODE, 10'h3ff)
        SOFT_RESET_REQUEST <= 1'b1;
        tick(6);
        SOFT_RESET_REQUEST <= 1'b0;
        WARNING_FEATURE_ENABLE <= 1'b0;
        tick(6);
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0000d0f8)
        $display("t_lock done");
    endtask
    task automatic t_lsm;
        hit(2);
        apb(0, 12'h00c, 0);
        `CHK(rd, 32'h0)
        SELF_RECEPTION_DISABLE_REQ <= 1'b1;
        TX_DELAY_COMP_ENABLE_REQ <= 1'b1;
        tick(6);
        `CHK({SELF_RECEPTION_DISABLE, TX_DELAY_COMP_ENABLE}, 2'b00)
        apb(1, 12'h004, 32'h0);
        tick(4);
        `CHK({SELF_RECEPTION_DISABLE, TX_DELAY_COMP_ENABLE}, 2'b11)
        $display("t_lsm done");
    endtask
    task automatic t_irq;
        WARNING_FEATURE_ENABLE <= 1'b1;
        tick(6);
        apb(1, 12'h004, 32'h00008800);
        apb(1, 12'h010, 32'hf);
        for (int k = 0; k < 4; k++) hit(k[2:0]);
        `CHK({BUSOFF_IRQ, ERROR_SUMMARY_IRQ, TX_WARNING_IRQ_FLAG, RX_WARNING_IRQ_FLAG}, 4'ha)
        `CHK(IRQ, 1'b1)
        apb(0, 12'h00c, 0);
        `CHK(rd, 32'hf)
        apb(1, 12'h010, 32'h0);
        apb(1, 12'h014, 32'hf);
        hit(0);
        apb(0, 12'h00c, 0);
        `CHK({IRQ, rd}, 33'h1)
        $display("t_irq done");
    endtask
    task automatic t_timer;
        apb(1, 12'h008, 32'h0000fffe);
        apb(0, 12'h008, 0);
        `CHK(rd[15:0] < 16'h0010, 1'b1)
        apb(1, 12'h004, 32'h00000020);
        apb(1, 12'h008, 32'h00008000);
        hit(4);
        apb(0, 12'h008, 0);
        `CHK(rd[15:0] < 16'h0020, 1'b1)
        apb(1, 12'h004, 32'h0);
        apb(1, 12'h008, 32'h00008000);
        hit(4);
        apb(0, 12'h008, 0);
        `CHK(rd[15:0] > 16'h8000, 1'b1)
        $display("t_timer done");
    endtask
    task automatic t_full_reset;
        apb(1, 12'h004, 32'h0000dcf8);
        @(posedge CLK);
        RESETN <= 1'b0;
        tick(2);
        RESETN <= 1'b1;
        tick(2);
        `CHK(MODE, 10'h000)
        apb(0, 12'h004, 0);
        `CHK(rd, 32'h0)
        $display("t_full_reset done");
    endtask
    initial begin
        RESETN <= 1'b0;
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        t_reset();
        t_lock();
        t_lsm();
        t_irq();
        t_timer();
        t_full_reset();
        complete_run();
    end
endmodule // cct_ctrl_timer_tb_top
bind cct_ctrl_timer cct_checker cct_checker_i (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INACTIVE_MODE(INACTIVE_MODE), .WARNING_FEATURE_ENABLE(WARNING_FEATURE_ENABLE), .MODE(MODE),
    .SELF_RECEPTION_DISABLE(SELF_RECEPTION_DISABLE), .TX_DELAY_COMP_ENABLE(TX_DELAY_COMP_ENABLE),
    .BUSOFF_IRQ(BUSOFF_IRQ), .ERROR_SUMMARY_IRQ(ERROR_SUMMARY_IRQ), .TX_WARNING_IRQ_FLAG(TX_WARNING_IRQ_FLAG));
